/* File: core/lrr_defines.svh */
/*
  Constants for the literal-return and rotate execution block.
  Assumes a 14-bit instruction word and a 15-bit program counter.
*/
`ifndef LRR_DEFINES_SVH
`define LRR_DEFINES_SVH

`define INSN_W        14
`define PC_W          15
`define STACK_DEPTH   16
`define SP_W          4
`define REG_ADDR_W    7
`define DATA_W        8
`define RET_OPC       4'hd
`define ROT_OPC       6'h0d
`define DEST_BIT      7
`define PC_RESET      15'h0000
`define W_RESET       8'h00

`endif

/* File: core/lrr_pkg.sv */
/*
  Types for the literal-return and rotate execution block.
  Assumes the defines header is compiled alongside.
*/
package lrr_pkg;

  typedef enum logic [1:0] {
    ST_EXEC  = 2'b00,
    ST_FLUSH = 2'b01
  } exec_state_t;

  typedef enum logic [1:0] {
    OP_NONE = 2'b00,
    OP_RETL = 2'b01,
    OP_ROTL = 2'b11
  } op_kind_t;

endpackage : lrr_pkg

/* File: core/rot_if.sv */
/*
  Interface between the decoder and the rotate unit.
  Assumes both ends share mclk_i.
*/
`timescale 1ns/1ps
interface rot_if;
  logic [7:0] operand;
  logic       carry_in;
  logic [7:0] result;
  logic       carry_out;

  modport core (output operand, output carry_in,
                input result, input carry_out);
  modport unit (input operand, input carry_in,
                output result, output carry_out);
endinterface : rot_if

/* File: core/rotate_unit.sv */
/*
  Rotate-left-through-carry datapath.
  Assumes the decoder presents operand and carry on the interface.
*/
`timescale 1ns/1ps
module rotate_unit (
  rot_if.unit rot
);

  // ****************************************
  // Rotate one place toward the top bit.
  // ****************************************
  always_comb begin
    rot.result    = {rot.operand[6:0], rot.carry_in};
    rot.carry_out = rot.operand[7];
  end

endmodule : rotate_unit

/* File: core/literal_return_and_rotate.sv */
/*
  Execution logic for the return_with_literal and
  rotate_left_through_carry instructions, with accumulator, carry flag,
  program counter and return stack.
  Assumes instructions arrive one per cycle from the fetch stage and data
  memory reads are combinational through reg_rdata_i.
*/
// Function
// - Return with literal loads its 8-bit immediate into the accumulator.
// - Return with literal pops the return stack into the program counter.
// - Return with literal is one word and two cycles, flushing the fetch.
// - Rotate left moves bits up, old carry to bit 0, old bit 7 to carry.
// - Destination bit 0 writes the accumulator, 1 writes the register.
`timescale 1ns/1ps
`include "lrr_defines.svh"
module literal_return_and_rotate
  import lrr_pkg::*;
(
  input  wire logic                     mclk_i,
  input  wire logic                     reset_i,
  input  wire logic                     insn_valid_i,
  input  wire logic [`INSN_W-1:0]       insn_i,
  input  wire logic                     push_i,
  input  wire logic [`PC_W-1:0]         push_addr_i,
  input  wire logic [`DATA_W-1:0]       reg_rdata_i,
  output logic [`REG_ADDR_W-1:0]        reg_addr_o,
  output logic                          reg_we_o,
  output logic [`DATA_W-1:0]            reg_wdata_o,
  output logic [`DATA_W-1:0]            accum_o,
  output logic                          carry_o,
  output logic [`PC_W-1:0]              pc_o,
  output logic                          pc_load_o,
  output logic                          flush_o,
  output logic [`PC_W-1:0]              stack_top_entry_o
);

  // ****************************************
  // State.
  // ****************************************
  exec_state_t            state_q, state_d;
  logic [`DATA_W-1:0]     accum_q, accum_d;
  logic                   carry_q, carry_d;
  logic [`PC_W-1:0]       pc_q, pc_d;
  logic [`SP_W-1:0]       sp_q, sp_d;
  logic [`PC_W-1:0]       stack_q [`STACK_DEPTH];
  logic [`DATA_W-1:0]     wdata_q, wdata_d;
  logic                   we_q, we_d;
  logic [`REG_ADDR_W-1:0] addr_q, addr_d;
  logic                   pcld_q, pcld_d;
  op_kind_t               op;
  logic                   pop;
  logic [`SP_W-1:0]       top_idx;
  logic                   push_ok;

  rot_if rot ();

  rotate_unit u_rot (
    .rot (rot)
  );

  // ****************************************
  // Decode.
  // ****************************************
  always_comb begin
    op = OP_NONE;
    if (insn_valid_i && state_q == ST_EXEC) begin
      if (insn_i[13:10] == `RET_OPC)
        op = OP_RETL;
      else if (insn_i[13:8] == `ROT_OPC)
        op = OP_ROTL;
    end
  end

  assign top_idx        = sp_q - 4'h1;
  assign pop            = (op == OP_RETL);
  assign push_ok        = push_i && op == OP_NONE && state_q == ST_EXEC;
  assign rot.operand    = reg_rdata_i;
  assign rot.carry_in   = carry_q;
  // A write-back shows its own address while its strobe stands.
  assign reg_addr_o     = we_q ? addr_q : insn_i[`REG_ADDR_W-1:0];
  assign stack_top_entry_o = stack_q[top_idx];

  // ****************************************
  // Sequencer.
  // ****************************************
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_EXEC: begin
        if (op == OP_RETL) begin
          state_d = ST_FLUSH;
        end
      end
      ST_FLUSH: begin
        state_d = ST_EXEC;
      end
      default: begin
        state_d = ST_EXEC;
      end
    endcase
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      state_q <= ST_EXEC;
    end else begin
      state_q <= state_d;
    end
  end

  // ****************************************
  // Accumulator and carry.
  // ****************************************
  always_comb begin
    accum_d = accum_q;
    carry_d = carry_q;
    case (op)
      OP_RETL: begin
        accum_d = insn_i[7:0];
      end
      OP_ROTL: begin
        carry_d = rot.carry_out;
        if (!insn_i[`DEST_BIT]) begin
          accum_d = rot.result;
        end
      end
      default: begin
        accum_d = accum_q;
      end
    endcase
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      accum_q <= `W_RESET;
      carry_q <= 1'b0;
    end else begin
      accum_q <= accum_d;
      carry_q <= carry_d;
    end
  end

  // ****************************************
  // Program counter and stack pointer.
  // ****************************************
  always_comb begin
    pc_d   = pc_q;
    sp_d   = sp_q;
    pcld_d = 1'b0;
    if (pop) begin
      pc_d   = stack_q[top_idx];
      sp_d   = top_idx;
      pcld_d = 1'b1;
    end else if (push_ok) begin
      sp_d = sp_q + 4'h1;
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      pc_q   <= `PC_RESET;
      sp_q   <= 4'h0;
      pcld_q <= 1'b0;
    end else begin
      pc_q   <= pc_d;
      sp_q   <= sp_d;
      pcld_q <= pcld_d;
    end
  end

  // ****************************************
  // Register write-back.
  // ****************************************
  always_comb begin
    wdata_d = wdata_q;
    addr_d  = addr_q;
    we_d    = 1'b0;
    if (op == OP_ROTL && insn_i[`DEST_BIT]) begin
      wdata_d = rot.result;
      addr_d  = insn_i[`REG_ADDR_W-1:0];
      we_d    = 1'b1;
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      wdata_q <= 8'h00;
      addr_q  <= 7'h00;
      we_q    <= 1'b0;
    end else begin
      wdata_q <= wdata_d;
      addr_q  <= addr_d;
      we_q    <= we_d;
    end
  end

  // ****************************************
  // Return stack entries.
  // ****************************************
  for (genvar i = 0; i < `STACK_DEPTH; i++) begin : g_stack
    logic [`PC_W-1:0] entry_d;

    always_comb begin
      entry_d = stack_q[i];
      if (push_ok && int'(sp_q) == i) begin
        entry_d = push_addr_i;
      end
    end

    always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
        stack_q[i] <= `PC_RESET;
      end else begin
        stack_q[i] <= entry_d;
      end
    end
  end

  // ****************************************
  // Outputs.
  // ****************************************
  assign accum_o     = accum_q;
  assign carry_o     = carry_q;
  assign pc_o        = pc_q;
  assign pc_load_o   = pcld_q;
  assign flush_o     = (state_q == ST_FLUSH);
  assign reg_we_o    = we_q;
  assign reg_wdata_o = wdata_q;

endmodule : literal_return_and_rotate

/* File: test/lrr_sva.sv */
/* Checker for the literal-return and rotate block, bound to its top.
   Assumes the opcode defines header is on the include path. */
`timescale 1ns/1ps
`include "lrr_defines.svh"
module lrr_sva (
  input wire logic        mclk_i,
  input wire logic        reset_i,
  input wire logic        insn_valid_i,
  input wire logic [13:0] insn_i,
  input wire logic [7:0]  reg_rdata_i,
  input wire logic [6:0]  reg_addr_o,
  input wire logic        reg_we_o,
  input wire logic [7:0]  reg_wdata_o,
  input wire logic [7:0]  accum_o,
  input wire logic        carry_o,
  input wire logic [14:0] pc_o,
  input wire logic        pc_load_o,
  input wire logic        flush_o,
  input wire logic [14:0] stack_top_entry_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  sequence ret_s;
    insn_valid_i && !flush_o && insn_i[13:10] == `RET_OPC;
  endsequence
  sequence rot_s;
    insn_valid_i && !flush_o && insn_i[13:8] == `ROT_OPC;
  endsequence
  a_ret_accum: assert property (
    ret_s |=> accum_o == $past(insn_i[7:0])) else $error("bad literal");
  a_ret_pop: assert property (
    ret_s |=> pc_load_o && pc_o == $past(stack_top_entry_o))
    else $error("bad return pc");
  a_ret_flush: assert property (
    ret_s |=> flush_o ##1 !flush_o) else $error("bad flush");
  a_rot_carry: assert property (
    rot_s |=> carry_o == $past(reg_rdata_i[7])) else $error("bad carry");
  a_rot_dest: assert property (
    rot_s |=> reg_we_o == $past(insn_i[7]) &&
      (reg_we_o ? reg_wdata_o : accum_o) ==
      {$past(reg_rdata_i[6:0]), $past(carry_o)}) else $error("bad dest");
  a_rot_keep: assert property (
    rot_s ##0 insn_i[7] |=> $stable(accum_o)) else $error("accum moved");
  a_rot_single: assert property (
    rot_s |=> !flush_o && $stable(pc_o)) else $error("rotate not single");
  a_wb_addr: assert property (
    rot_s ##0 insn_i[7] |=> reg_addr_o == $past(insn_i[6:0]))
    else $error("bad write address");
endmodule : lrr_sva
bind literal_return_and_rotate lrr_sva lrr_sva_i (.*);

/* File: test/tb.sv */
/* Self-checking bench for the literal-return and rotate block.
   Assumes the package, defines header and checker are compiled first. */
`timescale 1ns/1ps
`include "lrr_defines.svh"
module tb;
  logic        mclk_i = 1'h0, reset_i = 1'h1, insn_valid_i = 1'h0;
  logic        push_i = 1'h0, reg_we_o, carry_o, pc_load_o, flush_o;
  logic [13:0] insn_i = 14'h0;
  logic [14:0] push_addr_i = 15'h0, pc_o, stack_top_entry_o;
  logic [7:0]  reg_rdata_i = 8'h0, reg_wdata_o, accum_o;
  logic [6:0]  reg_addr_o;
  int          n_fail = 0, compares = 0;
  always #50 mclk_i = ~mclk_i;
  literal_return_and_rotate literal_return_and_rotate_i (.*);
  task automatic step;
    @(posedge mclk_i);
    #5;
  endtask : step
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic ret_scenario;
    push_i = 1'h1;
    push_addr_i = 15'h1234;
    step();
    push_addr_i = 15'h0abc;
    step();
    push_i = 1'h0;
    chk(stack_top_entry_o, 24'h0abc);
    insn_valid_i = 1'h1;
    insn_i = {4'hd, 2'h0, 8'ha5};
    step();
    insn_i = {4'hd, 2'h0, 8'h11};
    push_i = 1'h1;
    push_addr_i = 15'h7777;
    chk({accum_o, pc_o, pc_load_o}, {8'ha5, 15'h0abc, 1'h1});
    chk(flush_o, 24'h1);
    step();
    chk({accum_o, pc_load_o, flush_o}, 24'h294);
    chk(stack_top_entry_o, 24'h1234);
    insn_i = {4'hd, 2'h0, 8'h5a};
    step();
    insn_valid_i = 1'h0;
    push_i = 1'h0;
    chk(stack_top_entry_o, 24'h0);
    chk({accum_o, pc_o, pc_load_o}, {8'h5a, 15'h1234, 1'h1});
    step();
  endtask : ret_scenario
  task automatic rot_scenario;
    insn_valid_i = 1'h1;
    insn_i = {6'h0d, 1'h0, 7'h7f};
    reg_rdata_i = 8'he6;
    #1;
    chk(reg_addr_o, 24'h7f);
    step();
    chk({accum_o, carry_o, reg_we_o}, 24'h332);
    chk({pc_o, flush_o}, {15'h1234, 1'h0});
    insn_i = {6'h0d, 1'h1, 7'h05};
    reg_rdata_i = 8'h81;
    step();
    insn_valid_i = 1'h0;
    insn_i = {6'h0d, 1'h0, 7'h33};
    chk(reg_addr_o, 24'h05);
    chk({reg_we_o, reg_wdata_o, carry_o}, 24'h207);
    chk(accum_o, 24'hcc);
    step();
    chk(reg_we_o, 24'h0);
  endtask : rot_scenario
  task automatic reset_scenario;
    insn_valid_i = 1'h1;
    insn_i = {4'hd, 2'h0, 8'h3c};
    step();
    reset_i = 1'h1;
    insn_valid_i = 1'h0;
    #1;
    chk({accum_o, carry_o}, {`W_RESET, 1'h0});
    chk({pc_load_o, flush_o, reg_we_o}, 24'h0);
    chk(pc_o, `PC_RESET);
    chk(stack_top_entry_o, 24'h0);
    step();
    reset_i = 1'h0;
    insn_valid_i = 1'h1;
    insn_i = {6'h0d, 1'h0, 7'h12};
    reg_rdata_i = 8'h41;
    step();
    insn_valid_i = 1'h0;
    chk({accum_o, carry_o, flush_o}, 24'h208);
    step();
  endtask : reset_scenario
  task automatic finish_test;
    if (n_fail == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test
  initial begin
    repeat (4) @(posedge mclk_i);
    #5;
    reset_i = 1'h0;
    step();
    ret_scenario();
    rot_scenario();
    reset_scenario();
    finish_test();
  end
  initial begin
    #100000;
    n_fail++;
    finish_test();
  end
endmodule : tb
